// ==== verif/lf_transmitter.sv ====
// Behavioural LF transmitter and RTC source facing the wake-up logic.
`timescale 1ns/10ps
`default_nettype none
module lf_transmitter (
	input  wire logic sys_clk,
	output logic      rtc_clk_pin,
	output logic      carrier_detect,
	output logic      demod_data
);
	localparam int HB = 16;      // Cycles per half-bit, two RTC periods
	logic [3:0] ph     = 4'h0;   // Phase within a half-bit
	logic       idle   = 1'b1;   // Data line released between frames
	logic       wander = 1'b0;   // Level shown while released
	logic       car_v  = 1'b0;   // Carrier level from the frame task
	logic       dat_v  = 1'b0;   // Data level from the frame task
	// RTC rises 4 cycles into each half-bit, well clear of data edges
	assign rtc_clk_pin    = ph[2];
	assign carrier_detect = car_v;
	// Released data wanders so no stale level lingers
	assign demod_data     = idle ? wander : dat_v;
	// Free-running phase and wander level
	always @(negedge sys_clk) begin
		ph     <= ph + 4'h1;
		wander <= ~wander;
	end
	// One half-bit of carrier and data level
	task automatic half(input logic c, input logic d);
		car_v = c;
		dat_v = d;
		repeat (HB) @(negedge sys_clk);
	endtask : half
	// Burst, preamble, then pattern copies; missed zeros go out as silence
	task automatic send_frame(input int burst_h, input int pre, input int copies,
			input logic [15:0] halves, input logic [7:0] miss);
		idle = 1'b0;
		do @(negedge sys_clk); while (ph != 4'hF);
		for (int i = 0; i < burst_h; i++) half(1'b1, 1'b1);
		for (int i = 0; i < pre; i++) begin
			half(1'b0, i[0]);
			half(1'b0, ~i[0]);
		end
		for (int k = 0; k < copies; k++)
			for (int i = 7; i >= 0; i--) begin
				half(1'b0, halves[2*i+1] & ~miss[i]);
				half(1'b0, halves[2*i] & ~miss[i]);
			end
		car_v = 1'b0;
		idle = 1'b1;
	endtask : send_frame
endmodule : lf_transmitter
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the wake-up decision logic.
`timescale 1ns/10ps
`default_nettype none
module tb
	import wakeup_pkg::*;
;
	localparam int STEP  = 20;    // Shortened timeout step
	localparam int ONOFF = 1000;  // Shortened on/off burst floor
	logic       sys_clk = 1'b0;
	logic       rst, clear_wake_cmd, correlator_enable, onoff_mode_enable;
	logic       double_pattern_enable;
	logic [1:0] missed_zero_tolerance;
	logic [7:0] pattern_high_byte, pattern_low_byte, false_wakeup_count;
	logic [4:0] bit_duration_select;
	logic [2:0] timeout_select;
	wire logic  rtc_clk_pin, carrier_detect, demod_data;
	logic       wake;
	int         bad_count = 0;
	int         check_count = 0;
	int         exp_count = 0;      // Expected false wake-up tally
	int         cyc = 0;            // Hang guard
	integer     seed = 32'h2DFE;
	wakeup_control #(.TIMEOUT_STEP_CYCLES(STEP), .ONOFF_MIN_CYCLES(ONOFF)) i_wakeup_control (
		.sys_clk(sys_clk), .rst(rst), .rtc_clk_pin(rtc_clk_pin),
		.carrier_detect(carrier_detect), .demod_data(demod_data),
		.clear_wake_cmd(clear_wake_cmd), .correlator_enable(correlator_enable),
		.onoff_mode_enable(onoff_mode_enable), .double_pattern_enable(double_pattern_enable),
		.missed_zero_tolerance(missed_zero_tolerance), .pattern_high_byte(pattern_high_byte),
		.pattern_low_byte(pattern_low_byte), .bit_duration_select(bit_duration_select),
		.timeout_select(timeout_select), .wake(wake), .false_wakeup_count(false_wakeup_count));
	lf_transmitter i_lf_transmitter (.sys_clk(sys_clk), .rtc_clk_pin(rtc_clk_pin),
		.carrier_detect(carrier_detect), .demod_data(demod_data));
	always #10 sys_clk = ~sys_clk;
	// Cut a hang short well past the expected run length
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (bad_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Bounded wait for the wake output
	task automatic wait_wake(input int lim);
		int n;
		n = 0;
		while (wake !== 1'b1 && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : wait_wake
	// Manchester half-bits of a bit pattern, one sent as high then low
	function automatic logic [15:0] to_halves(input logic [7:0] b);
		for (int i = 0; i < 8; i++) to_halves[2*i +: 2] = b[i] ? 2'b10 : 2'b01;
	endfunction : to_halves
	// Whether a frame of this shape should wake the device
	function automatic logic exp_wake(input int burst_h, input int pre, input int copies,
			input int m);
		return burst_h > 0 && (burst_h <= 32 || (onoff_mode_enable && burst_h * 16 <= ONOFF))
			&& pre >= 4 && copies >= (double_pattern_enable ? 2 : 1)
			&& m <= missed_zero_tolerance;
	endfunction : exp_wake
	// One framed attempt; zeros sit at even bit positions so misses have room
	task automatic run(input int burst_h, input int pre, input int copies, input int m);
		logic [7:0] bits;
		logic       ok;
		logic       hi;
		bits = 8'($random(seed)) & 8'hAA;
		ok = exp_wake(burst_h, pre, copies, m);
		{pattern_high_byte, pattern_low_byte} = to_halves(bits);
		i_lf_transmitter.send_frame(burst_h, pre, copies, to_halves(bits),
			{1'b0, m > 0, 1'b0, m > 1, 1'b0, m > 2, 1'b0, m > 3});
		chk("wake_early", 16'h0000, {15'h0000, wake});
		if (ok) begin
			wait_wake(40);
			chk("wake", 16'h0001, {15'h0000, wake});
			clear_wake_cmd = 1'b1;
			@(negedge sys_clk);
			clear_wake_cmd = 1'b0;
			@(negedge sys_clk);
			chk("wake_clear", 16'h0000, {15'h0000, wake});
		end else begin
			hi = 1'b0;
			repeat (1600) begin
				@(negedge sys_clk);
				hi = hi | wake;
			end
			chk("wake_fail", 16'h0000, {15'h0000, hi});
			if (burst_h > 0) exp_count++;
		end
		chk("false_count", 16'(exp_count), {8'h00, false_wakeup_count});
	endtask : run
	initial begin
		int n;
		rst = 1'b1;
		clear_wake_cmd = 1'b0;
		correlator_enable = 1'b0;
		onoff_mode_enable = 1'b0;
		double_pattern_enable = 1'b0;
		missed_zero_tolerance = 2'h0;
		{pattern_high_byte, pattern_low_byte} = 16'h0000;
		bit_duration_select = BIT_SEL_MIN;
		timeout_select = 3'h0;
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		// Carrier alone wakes; every timeout code, code zero released by command
		for (int c = 0; c < 8; c++) begin
			timeout_select = 3'(c);
			fork
				i_lf_transmitter.send_frame(1, 0, 0, 16'h0000, 8'h00);
				begin
					wait_wake(30);
					chk("wake_carrier", 16'h0001, {15'h0000, wake});
					n = 0;
					while (wake === 1'b1 && n < 400) begin
						@(negedge sys_clk);
						n++;
						if (c == 0) clear_wake_cmd = (n == 50);
					end
					chk("wake_len", 16'(c == 0 ? 51 : c * STEP), 16'(n));
				end
			join
		end
		timeout_select = 3'h0;
		correlator_enable = 1'b1;
		// Each tolerance at its limit and one past it
		for (int t = 0; t < 4; t++) begin
			missed_zero_tolerance = 2'(t);
			for (int m = t; m <= t + 1; m++) run(8, 4, 1, m);
		end
		missed_zero_tolerance = 2'h0;
		run(0, 4, 1, 0);
		run(8, 0, 0, 0);
		run(40, 4, 1, 0);
		onoff_mode_enable = 1'b1;
		run(40, 4, 1, 0);
		onoff_mode_enable = 1'b0;
		double_pattern_enable = 1'b1;
		run(8, 4, 1, 0);
		run(8, 4, 2, 0);
		double_pattern_enable = 1'b0;
		// Random tolerance and miss counts
		for (int i = 0; i < 6; i++) begin
			missed_zero_tolerance = 2'($random(seed));
			run(8, 4, 1, ($random(seed) & 7) % 5);
		end
		end_sim();
	end
endmodule : tb
`default_nettype wire

// ==== verilog/bit_clock.sv ====
// Bit-period timer derived from the RTC tick.
`timescale 1ns/10ps
`default_nettype none
module bit_clock
	import wakeup_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       rtc_rise,
	input  wire logic       restart,
	input  wire logic [4:0] bit_duration_select,
	output logic            half_tick,
	output logic            bit_tick
);
	logic [4:0] cnt_reg;     // RTC periods into the current bit
	logic [4:0] cnt_next;
	logic       half_next;
	logic       bit_next;
	logic [4:0] last;        // Final count of one bit
	logic [4:0] mid;         // Count at the half-bit point

	// Codes below the table floor run at the fastest legal rate
	assign last = (bit_duration_select < BIT_SEL_MIN) ? BIT_SEL_MIN : bit_duration_select;
	assign mid  = {1'b0, last[4:1]};

	// Next count and tick pulses
	always_comb begin
		cnt_next  = cnt_reg;
		half_next = 1'b0;
		bit_next  = 1'b0;
		if (restart) begin
			cnt_next = 5'h00;
		end else if (rtc_rise) begin
			if (cnt_reg == last) begin
				// Bit boundary also ends the second half-bit
				cnt_next  = 5'h00;
				bit_next  = 1'b1;
				half_next = 1'b1;
			end else begin
				cnt_next  = cnt_reg + 5'h01;
				half_next = (cnt_reg == mid);
			end
		end
	end

	// Registers only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_reg   <= 5'h00;
			half_tick <= 1'b0;
			bit_tick  <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			half_tick <= half_next;
			bit_tick  <= bit_next;
		end
	end
endmodule : bit_clock
`default_nettype wire

// ==== verilog/wakeup_control.sv ====
// Wake-up decision: burst check, preamble, pattern correlation, wake hold.
`timescale 1ns/10ps
`default_nettype none
module wakeup_control
	import wakeup_pkg::*;
#(
	parameter int TIMEOUT_STEP_CYCLES = TIMEOUT_STEP_CYC,  // Cycles per 50 ms step
	parameter int ONOFF_MIN_CYCLES    = ONOFF_MIN_CYC      // Cycles in 10 ms
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       rtc_clk_pin,           // RTC clock, asynchronous
	input  wire logic       carrier_detect,        // Frequency detector, asynchronous
	input  wire logic       demod_data,            // Sliced data, asynchronous
	input  wire logic       clear_wake_cmd,        // Release pulse from command port
	input  wire logic       correlator_enable,
	input  wire logic       onoff_mode_enable,
	input  wire logic       double_pattern_enable,
	input  wire logic [1:0] missed_zero_tolerance,
	input  wire logic [7:0] pattern_high_byte,
	input  wire logic [7:0] pattern_low_byte,
	input  wire logic [4:0] bit_duration_select,
	input  wire logic [2:0] timeout_select,
	output logic            wake,
	output logic [7:0]      false_wakeup_count
);
	logic [2:0]  sync1_reg;          // First synchroniser stage
	logic [2:0]  sync2_reg;          // Second synchroniser stage
	logic        rtc_prev_reg;       // For RTC edge detection
	logic        carrier_prev_reg;   // For carrier edge detection
	logic        carrier;
	logic        carrier_rise;       // New burst, not a lingering one
	logic        data_s;
	logic        rtc_rise;
	logic        half_tick;
	logic        bit_tick;
	wake_state_t state_reg, state_next;
	logic [15:0] shift_reg, shift_next;      // Received half-bit symbols
	logic [5:0]  bits_reg, bits_next;        // Bit periods in burst, then since burst end
	logic [19:0] burst_reg, burst_next;      // Burst length in clock cycles
	logic        first_reg, first_next;      // First of a double pattern seen
	logic [24:0] tmr_reg, tmr_next;          // Wake hold timer
	logic        wake_next;
	logic [7:0]  false_next;
	logic        false_event;
	logic        restart;
	logic        match;
	logic        preamble_seen;
	logic        burst_long;
	logic [24:0] limit;                      // Timeout in cycles, zero is none

	// Count zeros lost as silence; any other wrong symbol fails outright
	function automatic logic pattern_ok(input logic [15:0] rx, input logic [15:0] pat,
	                                    input logic [1:0] tol);
		logic [2:0] miss;
		logic       bad;
		miss = 3'h0;
		bad  = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (rx[2*i +: 2] != pat[2*i +: 2]) begin
				// A one seen where a zero belongs is not a missed zero
				if (pat[2*i +: 2] == ZERO_SYMBOL && rx[2*i +: 2] == 2'h0) begin
					miss = miss + 3'h1;
				end else begin
					bad = 1'b1;
				end
			end
		end
		return !bad && (miss <= {1'b0, tol});
	endfunction : pattern_ok

	// Two flip-flops on every pin input before use
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_reg    <= 3'h0;
			sync2_reg    <= 3'h0;
			rtc_prev_reg <= 1'b0;
			carrier_prev_reg <= 1'b0;
		end else begin
			sync1_reg    <= {rtc_clk_pin, carrier_detect, demod_data};
			sync2_reg    <= sync1_reg;
			rtc_prev_reg <= sync2_reg[2];
			carrier_prev_reg <= sync2_reg[1];
		end
	end
	assign carrier  = sync2_reg[1];
	// A burst cut as too long must end before it can re-arm detection
	assign carrier_rise = sync2_reg[1] & ~carrier_prev_reg;
	assign data_s   = sync2_reg[0];
	assign rtc_rise = sync2_reg[2] & ~rtc_prev_reg;

	// Bit timing realigns when the burst ends
	assign restart = (state_reg == ST_CARRIER) && !carrier;

	bit_clock u_bit_clock (
		.sys_clk             (sys_clk),
		.rst                 (rst),
		.rtc_rise            (rtc_rise),
		.restart             (restart),
		.bit_duration_select (bit_duration_select),
		.half_tick           (half_tick),
		.bit_tick            (bit_tick)
	);

	// Decode helpers; MSB arrives first so it ends at the top
	// Includes the sample being taken this cycle
	assign match = pattern_ok({shift_reg[14:0], data_s}, {pattern_high_byte, pattern_low_byte},
	                          missed_zero_tolerance);
	assign preamble_seen = (shift_reg[7:0] == PREAMBLE_A) || (shift_reg[7:0] == PREAMBLE_B);
	// On/off mode may not cut the burst before the 10 ms floor
	assign burst_long = (bits_reg > BURST_MAX_BITS) &&
	                    (!onoff_mode_enable || burst_reg > 20'(ONOFF_MIN_CYCLES));
	assign limit = 25'(TIMEOUT_STEP_CYCLES) * {22'h0, timeout_select};

	// Sequencing of frequency check, preamble, pattern and wake hold
	always_comb begin
		state_next  = state_reg;
		shift_next  = half_tick ? {shift_reg[14:0], data_s} : shift_reg;
		bits_next   = bit_tick ? bits_reg + 6'h01 : bits_reg;
		burst_next  = (burst_reg == 20'hFFFFF) ? burst_reg : burst_reg + 20'h00001;
		first_next  = first_reg;
		tmr_next    = tmr_reg;
		false_event = 1'b0;
		case (state_reg)
			ST_LISTEN: begin
				bits_next  = 6'h00;
				burst_next = 20'h00000;
				first_next = 1'b0;
				if (carrier_rise) begin
					// Frequency detection comes first
					state_next = correlator_enable ? ST_CARRIER : ST_WAKE;
				end
			end
			ST_CARRIER: begin
				if (burst_long) begin
					state_next  = ST_LISTEN;
					false_event = 1'b1;
				end else if (!carrier) begin
					state_next = ST_PREAMBLE;
					bits_next  = 6'h00;
					// Fill that matches no symbol, so stale bits never pass
					shift_next = 16'hFFFF;
				end
			end
			ST_PREAMBLE: begin
				if (preamble_seen) begin
					state_next = ST_PATTERN;
				end else if (bits_reg >= PREAMBLE_WAIT) begin
					state_next  = ST_LISTEN;
					false_event = 1'b1;
				end
			end
			ST_PATTERN: begin
				// Bit boundaries only, so a half-bit slip cannot match
				if (bit_tick && match) begin
					if (double_pattern_enable && !first_reg) begin
						// Second copy must follow; refill so it is fresh
						first_next = 1'b1;
						shift_next = 16'hFFFF;
					end else begin
						state_next = ST_DELAY;
					end
				end else if (bits_reg >= FRAME_MAX_BITS + (first_reg ? 6'h08 : 6'h00)) begin
					// Window closed without a match
					state_next  = ST_LISTEN;
					false_event = 1'b1;
				end
			end
			ST_DELAY: begin
				if (bit_tick) begin
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				tmr_next = tmr_reg + 25'h0000001;
				if (clear_wake_cmd) begin
					state_next = ST_LISTEN;
				end else if (limit != 25'h0 && tmr_reg >= limit - 25'h0000001) begin
					state_next = ST_LISTEN;
				end
			end
			default: begin
				state_next = ST_LISTEN;
			end
		endcase
		// Timer zeroed outside wake so counting starts at the rising edge
		if (state_next != ST_WAKE) begin
			tmr_next = 25'h0;
		end
		wake_next  = (state_next == ST_WAKE);
		false_next = false_event ? false_wakeup_count + 8'h01
		                         : false_wakeup_count;
	end

	// State registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg          <= ST_LISTEN;
			shift_reg          <= 16'h0000;
			bits_reg           <= 6'h00;
			burst_reg          <= 20'h00000;
			first_reg          <= 1'b0;
			tmr_reg            <= 25'h0;
			wake               <= 1'b0;
			false_wakeup_count <= FALSE_CNT_RESET;
		end else begin
			state_reg          <= state_next;
			shift_reg          <= shift_next;
			bits_reg           <= bits_next;
			burst_reg          <= burst_next;
			first_reg          <= first_next;
			tmr_reg            <= tmr_next;
			wake               <= wake_next;
			false_wakeup_count <= false_next;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_pattern_done;
		state_reg == ST_DELAY;
	endsequence
	sequence s_delay_tick;
		s_pattern_done ##0 bit_tick;
	endsequence

	a_corr_off_wake: assert property (state_reg == ST_LISTEN && carrier_rise && !correlator_enable
		|=> wake) else $error("carrier alone did not wake");
	a_wake_after_bit: assert property (s_delay_tick |=> wake && state_reg == ST_WAKE)
		else $error("wake not raised one bit after pattern");
	a_wake_source: assert property ($rose(wake) && $past(correlator_enable) |-> $past(state_reg)
		== ST_DELAY) else $error("wake from wrong phase");
	a_release_cmd: assert property (wake && clear_wake_cmd |=> !wake && state_reg == ST_LISTEN)
		else $error("release command ignored");
	a_timer_start: assert property ($rose(wake) |-> tmr_reg == 25'h0)
		else $error("timeout count not at zero on wake");
	a_timeout_end: assert property (wake && limit != 25'h0 && tmr_reg == limit - 25'h0000001
		&& !clear_wake_cmd |=> !wake) else $error("timeout did not end wake");
	a_false_count: assert property (false_event |=> false_wakeup_count ==
		$past(false_wakeup_count) + 8'h01) else $error("false count not bumped");
	a_burst_drop: assert property (state_reg == ST_CARRIER && burst_long |=>
		state_reg == ST_LISTEN ##1 !wake) else $error("long burst not dropped");
	a_preamble_wait: assert property (state_reg == ST_PREAMBLE && !preamble_seen &&
		bits_reg >= PREAMBLE_WAIT |=> state_reg == ST_LISTEN && !wake)
		else $error("missing preamble not rejected");
	a_pattern_fail: assert property (state_reg == ST_PATTERN && false_event |=> !wake
		&& state_reg == ST_LISTEN) else $error("failed pattern woke");
	a_count_quiet: assert property (!false_event |=> $stable(false_wakeup_count))
		else $error("false count changed without event");
endmodule : wakeup_control
`default_nettype wire

// ==== verilog/wakeup_pkg.sv ====
// Constants and state encoding shared by the wake-up decision logic.
package wakeup_pkg;
	localparam int          CLK_HZ            = 50_000_000;  // System clock rate
	localparam int          TIMEOUT_STEP_MS   = 50;          // Timeout granularity
	localparam int          TIMEOUT_STEP_CYC  = CLK_HZ / 1000 * TIMEOUT_STEP_MS;
	localparam int          ONOFF_MIN_MS      = 10;          // On/off burst floor
	localparam int          ONOFF_MIN_CYC     = CLK_HZ / 1000 * ONOFF_MIN_MS;
	localparam logic [5:0]  BURST_MAX_BITS    = 6'h10;       // Sixteen bit periods
	localparam logic [5:0]  PREAMBLE_WAIT     = 6'h10;       // Sixteen bit periods
	localparam logic [5:0]  FRAME_MAX_BITS    = 6'h28;       // Preamble plus pattern
	localparam logic [4:0]  BIT_SEL_MIN       = 5'h03;       // Code for 4 RTC periods
	localparam logic [7:0]  PREAMBLE_A        = 8'h66;       // Half-bits of 0101
	localparam logic [7:0]  PREAMBLE_B        = 8'h99;       // Half-bits of 1010
	localparam logic [1:0]  ZERO_SYMBOL       = 2'h1;        // Low then high
	localparam logic [7:0]  FALSE_CNT_RESET   = 8'h00;

	typedef enum logic [2:0] {
		ST_LISTEN,
		ST_CARRIER,
		ST_PREAMBLE,
		ST_PATTERN,
		ST_DELAY,
		ST_WAKE
	} wake_state_t;
endpackage : wakeup_pkg
